// >>> pif_flag_bank.sv
`timescale 1ns/1ps
module pif_flag_bank #(
	parameter int W = 6
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// hardware events
	input  wire logic [W-1:0] set,
	// software write
	input  wire logic [W-1:0] wr_en,
	input  wire logic [W-1:0] wr_val,
	// flag state
	output logic      [W-1:0] q
);

	if (W < 1) begin : g_w_chk
		$error("pif_flag_bank: W must be at least 1");
	end

	logic [W-1:0] flag_ff;
	wire  [W-1:0] nxt_flag;

	// --------------------------------------------
	// set wins over a write in the same cycle
	// --------------------------------------------
	assign nxt_flag = set | (wr_en & wr_val) | (~wr_en & flag_ff);
	assign q        = flag_ff;

	always_ff @(posedge clk) begin
		if (srst)
			flag_ff <= '0;
		else
			flag_ff <= nxt_flag;
	end

endmodule : pif_flag_bank

// >>> pif_irq_flags.sv
`timescale 1ns/1ps
module pif_irq_flags #(
	parameter int DW = 32
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          srst,
	// wishbone slave
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [DW-1:0] wb_dat_i,
	output logic      [DW-1:0] wb_dat_o,
	output logic               wb_ack_o,
	// peripheral events
	input  wire logic          gate_active,
	input  wire logic          conv_done,
	input  wire logic          sync_serial_done,
	input  wire logic          capcmp_one_evt,
	input  wire logic          capcmp_one_pwm,
	input  wire logic          capcmp_two_evt,
	input  wire logic          capcmp_two_pwm,
	input  wire logic          period_match,
	input  wire logic          wide_timer_ovf,
	// serial data path
	input  wire logic          rx_byte_valid,
	input  wire logic [7:0]    rx_byte,
	input  wire logic          tx_taken,
	output logic      [7:0]    tx_byte,
	output logic               tx_load,
	// requests
	output logic               periph_irq,
	output logic               irq,
	output logic      [7:0]    option_settings
);

	if (DW < pif_pkg::EV_W) begin : g_dw_chk
		$error("pif_irq_flags: DW too narrow");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]              ctrl_ff;
	logic [7:0]              opt_ff;
	logic [7:0]              en1_ff;
	logic                    en2_ff;
	logic                    gate_flag_ff;
	logic                    gate_prev_ff;
	logic                    rx_full_ff;
	logic [7:0]              rx_data_ff;
	logic                    tx_empty_ff;
	logic [7:0]              tx_byte_ff;
	logic                    tx_load_ff;
	logic [pif_pkg::EV_W-1:0] ev_st_ff;
	logic [pif_pkg::EV_W-1:0] ev_msk_ff;
	logic                    periph_irq_ff;
	logic                    irq_ff;
	logic                    ack_ff;
	logic [DW-1:0]           dat_ff;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
	wire bus_rd   = bus_req & ~wb_we_i;
	wire hit_ctrl = wb_adr_i == pif_pkg::OFS_CTRL;
	wire hit_en1  = wb_adr_i == pif_pkg::OFS_EN1;
	wire hit_en2  = wb_adr_i == pif_pkg::OFS_EN2;
	wire hit_req1 = wb_adr_i == pif_pkg::OFS_REQ1;
	wire hit_req2 = wb_adr_i == pif_pkg::OFS_REQ2;
	wire hit_rxd  = wb_adr_i == pif_pkg::OFS_RXD;
	wire hit_txd  = wb_adr_i == pif_pkg::OFS_TXD;
	wire hit_opt  = wb_adr_i == pif_pkg::OFS_OPT;
	wire hit_evst = wb_adr_i == pif_pkg::OFS_EVST;
	wire hit_evm  = wb_adr_i == pif_pkg::OFS_EVMSK;
	wire wr_ctrl  = bus_wr & hit_ctrl;
	wire wr_en1   = bus_wr & hit_en1;
	wire wr_en2   = bus_wr & hit_en2;
	wire wr_req1  = bus_wr & hit_req1;
	wire wr_req2  = bus_wr & hit_req2;
	wire wr_txd   = bus_wr & hit_txd;
	wire wr_opt   = bus_wr & hit_opt;
	wire wr_evm   = bus_wr & hit_evm;
	wire rd_rxd   = bus_rd & hit_rxd;
	wire rd_evst  = bus_rd & hit_evst;

	// ----------------------------------------
	// latched request flags
	// ----------------------------------------
	wire [pif_pkg::NFLAG-1:0] flag_q;
	wire [pif_pkg::NFLAG-1:0] hw_set;
	wire [pif_pkg::NFLAG-1:0] flag_wen;
	wire [pif_pkg::NFLAG-1:0] flag_wval;

	// order: cc2, conv, sync, cc1, period, overflow
	assign hw_set = {
		capcmp_two_evt & ~capcmp_two_pwm,
		conv_done,
		sync_serial_done,
		capcmp_one_evt & ~capcmp_one_pwm,
		period_match,
		wide_timer_ovf
	};

	assign flag_wen  = {wr_req2, {5{wr_req1}}};
	assign flag_wval = {
		wb_dat_i[pif_pkg::B_CC2],
		wb_dat_i[pif_pkg::B_CONV],
		wb_dat_i[pif_pkg::B_SYNC],
		wb_dat_i[pif_pkg::B_CC1],
		wb_dat_i[pif_pkg::B_PER],
		wb_dat_i[pif_pkg::B_OVF]
	};

	pif_flag_bank #(
		.W      (pif_pkg::NFLAG)
	) u_flags (
		.clk    (clk),
		.srst   (srst),
		.set    (hw_set),
		.wr_en  (flag_wen),
		.wr_val (flag_wval),
		.q      (flag_q)
	);

	wire cc2_flag = flag_q[5];

	// ----------------------------------------
	// register read views
	// ----------------------------------------
	wire [7:0] req1_view = {
		gate_flag_ff,
		flag_q[4],
		rx_full_ff,
		tx_empty_ff,
		flag_q[3],
		flag_q[2],
		flag_q[1],
		flag_q[0]
	};
	wire [7:0] req2_view = {7'h00, cc2_flag};
	wire [7:0] en2_view  = {7'h00, en2_ff};

	wire [7:0] byte_view =
		hit_ctrl ? ctrl_ff :
		hit_en1  ? en1_ff :
		hit_en2  ? en2_view :
		hit_req1 ? req1_view :
		hit_req2 ? req2_view :
		hit_rxd  ? rx_data_ff :
		hit_txd  ? tx_byte_ff :
		hit_opt  ? opt_ff : 8'h00;

	wire [DW-1:0] rd_word =
		hit_evst ? DW'(ev_st_ff) :
		hit_evm  ? DW'(ev_msk_ff) : DW'(byte_view);

	// ----------------------------------------
	// peripheral request gating
	// ----------------------------------------
	wire any_req1 = |(req1_view & en1_ff);
	wire any_req2 = cc2_flag & en2_ff;
	wire nxt_periph_irq = ctrl_ff[pif_pkg::B_GIE]
		& ctrl_ff[pif_pkg::B_PERIPHERAL_IRQ_GATE]
		& (any_req1 | any_req2);

	// ----------------------------------------
	// serial buffer flags
	// ----------------------------------------
	wire nxt_rx_full  = rx_byte_valid | (rx_full_ff & ~rd_rxd);
	wire nxt_tx_empty = wr_txd ? 1'b0 : (tx_taken | tx_empty_ff);

	// ----------------------------------------
	// sticky event status
	// ----------------------------------------
	wire [pif_pkg::EV_W-1:0] ev_now = {
		hw_set[5],
		gate_prev_ff & ~gate_active,
		conv_done,
		rx_byte_valid & ~rx_full_ff,
		tx_taken & ~tx_empty_ff,
		sync_serial_done,
		hw_set[2],
		period_match,
		wide_timer_ovf
	};
	wire [pif_pkg::EV_W-1:0] nxt_ev_st =
		ev_now | (ev_st_ff & ~{pif_pkg::EV_W{rd_evst}});

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_ff <= pif_pkg::RST_CTRL;
			opt_ff  <= pif_pkg::RST_OPT;
			en1_ff  <= pif_pkg::RST_EN1;
			en2_ff  <= pif_pkg::RST_EN2;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= wb_dat_i[7:0];
			if (wr_opt)
				opt_ff <= wb_dat_i[7:0];
			if (wr_en1)
				en1_ff <= wb_dat_i[7:0];
			if (wr_en2)
				en2_ff <= wb_dat_i[0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			gate_flag_ff <= 1'b0;
			gate_prev_ff <= 1'b0;
			rx_full_ff   <= 1'b0;
			rx_data_ff   <= pif_pkg::RST_BYTE;
		end else begin
			gate_flag_ff <= ~gate_active;
			gate_prev_ff <= gate_active;
			rx_full_ff   <= nxt_rx_full;
			if (rx_byte_valid)
				rx_data_ff <= rx_byte;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tx_empty_ff <= pif_pkg::RST_TXE;
			tx_byte_ff  <= pif_pkg::RST_BYTE;
			tx_load_ff  <= 1'b0;
		end else begin
			tx_empty_ff <= nxt_tx_empty;
			tx_load_ff  <= wr_txd;
			if (wr_txd)
				tx_byte_ff <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ev_st_ff      <= pif_pkg::RST_EV;
			ev_msk_ff     <= pif_pkg::RST_EV;
			periph_irq_ff <= 1'b0;
			irq_ff        <= 1'b0;
		end else begin
			ev_st_ff      <= nxt_ev_st;
			periph_irq_ff <= nxt_periph_irq;
			irq_ff        <= |(ev_st_ff & ev_msk_ff);
			if (wr_evm)
				ev_msk_ff <= wb_dat_i[pif_pkg::EV_W-1:0];
		end
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ack_ff <= 1'b0;
			dat_ff <= '0;
		end else begin
			ack_ff <= bus_req;
			if (bus_rd)
				dat_ff <= rd_word;
		end
	end

	assign wb_ack_o        = ack_ff;
	assign wb_dat_o        = dat_ff;
	assign tx_byte         = tx_byte_ff;
	assign tx_load         = tx_load_ff;
	assign periph_irq      = periph_irq_ff;
	assign irq             = irq_ff;
	assign option_settings = opt_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	en2_upper_zero_a: assert property (
		bus_rd && hit_en2 |=> wb_ack_o && wb_dat_o[DW-1:1] == '0
	) else $error("upper bits of second enable not zero");

	peripheral_irq_gate_blocks_a: assert property (
		!ctrl_ff[pif_pkg::B_PERIPHERAL_IRQ_GATE] |=> !periph_irq
	) else $error("request passed with peripheral gate off");

	flag_any_enable_a: assert property (
		conv_done && !en1_ff[pif_pkg::B_CONV] && !ctrl_ff[pif_pkg::B_GIE]
		|=> req1_view[pif_pkg::B_CONV]
	) else $error("flag not set while disabled");

	gate_mirror_a: assert property (
		!$past(srst) |-> gate_flag_ff == !$past(gate_active)
	) else $error("gate flag does not mirror gate");

	sticky_hold_a: assert property (
		!wr_req1 && !wr_req2 |=> (flag_q & $past(flag_q)) == $past(flag_q)
	) else $error("sticky flag dropped without write");

	rx_clear_read_a: assert property (
		rd_rxd && !rx_byte_valid ##1 !rx_byte_valid |-> ##1 !rx_full_ff[*1]
	) else $error("receive flag not cleared by read");

	rx_full_set_a: assert property (
		rx_byte_valid |=> rx_full_ff ##1 (rx_full_ff || $past(rd_rxd))
	) else $error("receive flag not held");

	tx_write_a: assert property (
		wr_txd |=> !tx_empty_ff && tx_load && tx_byte == $past(wb_dat_i[7:0])
	) else $error("transmit write not taken");

	pwm_ignored_a: assert property (
		capcmp_one_pwm && !wr_req1 && !req1_view[pif_pkg::B_CC1]
		|=> !req1_view[pif_pkg::B_CC1]
	) else $error("pwm mode set capture flag");

	req2_upper_a: assert property (
		bus_rd && hit_req2 |=> wb_dat_o[DW-1:1] == '0
	) else $error("upper bits of second request not zero");
	gie_blocks_a: assert property (
		!ctrl_ff[pif_pkg::B_GIE] ##1 !ctrl_ff[pif_pkg::B_GIE] |-> !periph_irq
	) else $error("request passed with global gate off");
	gated_or_a: assert property (
		ctrl_ff[pif_pkg::B_GIE] && ctrl_ff[pif_pkg::B_PERIPHERAL_IRQ_GATE]
		&& (any_req1 || any_req2) |=> periph_irq
	) else $error("gated request not raised");

	sw_raise_a: assert property (
		wr_req1 && wb_dat_i[pif_pkg::B_SYNC] |=> req1_view[pif_pkg::B_SYNC]
	) else $error("software write of one did not raise flag");

	ev_read_a: assert property (
		rd_evst && ev_now == '0 |=> ev_st_ff == '0
	) else $error("event status not cleared by read");

	rx_read_c: cover property (rx_byte_valid ##[1:20] rd_rxd);
	irq_raise_c: cover property ($rose(periph_irq));
	tx_cycle_c: cover property (tx_load ##[1:260] tx_taken);
	ev_irq_c: cover property ($rose(irq));

endmodule : pif_irq_flags

// >>> pif_periph_model.sv
`timescale 1ns/1ps
module pif_periph_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// bench commands
	input  wire logic [8:0] fire,
	input  wire logic [7:0] rx_val,
	input  wire logic [7:0] slow,
	input  wire logic       tx_load,
	// events toward the block
	output logic            wide_timer_ovf,
	output logic            period_match,
	output logic            capcmp_one_evt,
	output logic            sync_serial_done,
	output logic            conv_done,
	output logic            capcmp_two_evt,
	output logic            rx_byte_valid,
	output logic      [7:0] rx_byte,
	output logic            tx_taken
);
	logic [8:0] pulse_ff;
	logic [7:0] cnt_ff;
	logic       pend_ff;

	assign wide_timer_ovf   = pulse_ff[0];
	assign period_match     = pulse_ff[1];
	assign capcmp_one_evt   = pulse_ff[2];
	assign sync_serial_done = pulse_ff[3];
	assign rx_byte_valid    = pulse_ff[5];
	assign conv_done        = pulse_ff[6];
	assign capcmp_two_evt   = pulse_ff[8];

	// data line shows garbage outside the valid pulse
	always_ff @(posedge clk) begin
		pulse_ff <= srst ? 9'h000 : fire;
		rx_byte  <= fire[5] ? rx_val : ~rx_byte;
	end

	// usart takes the byte after a settable delay
	always_ff @(posedge clk) begin
		tx_taken <= 1'b0;
		if (srst) begin
			pend_ff <= 1'b0;
		end else if (tx_load) begin
			pend_ff <= 1'b1;
			cnt_ff  <= slow;
		end else if (pend_ff && cnt_ff == 8'h00) begin
			tx_taken <= 1'b1;
			pend_ff  <= 1'b0;
		end else if (pend_ff) begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end
endmodule : pif_periph_model

// >>> pif_pkg.sv
package pif_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_EN1   = 8'h04;
	localparam logic [7:0] OFS_EN2   = 8'h08;
	localparam logic [7:0] OFS_REQ1  = 8'h0C;
	localparam logic [7:0] OFS_REQ2  = 8'h10;
	localparam logic [7:0] OFS_RXD   = 8'h14;
	localparam logic [7:0] OFS_TXD   = 8'h18;
	localparam logic [7:0] OFS_OPT   = 8'h1C;
	localparam logic [7:0] OFS_EVST  = 8'h20;
	localparam logic [7:0] OFS_EVMSK = 8'h24;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int B_GIE   = 7;
	localparam int B_PERIPHERAL_IRQ_GATE  = 6;
	localparam int B_GATE  = 7;
	localparam int B_CONV  = 6;
	localparam int B_RXF   = 5;
	localparam int B_TXE   = 4;
	localparam int B_SYNC  = 3;
	localparam int B_CC1   = 2;
	localparam int B_PER   = 1;
	localparam int B_OVF   = 0;
	localparam int B_CC2   = 0;
	localparam int B_EVCC2 = 8;
	localparam int EV_W    = 9;
	localparam int NFLAG   = 6;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [7:0]      RST_CTRL = 8'h00;
	localparam logic [7:0]      RST_OPT  = 8'hFF;
	localparam logic [7:0]      RST_EN1  = 8'h00;
	localparam logic            RST_EN2  = 1'b0;
	localparam logic [7:0]      RST_BYTE = 8'h00;
	localparam logic [EV_W-1:0] RST_EV   = 9'h000;
	localparam logic            RST_TXE  = 1'b1;

endpackage : pif_pkg

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, gate = 0, pwm1 = 0, pwm2 = 0;
	logic [7:0]  adr = 8'h00, rxv = 8'h00, slow = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rd, dat_o;
	logic [8:0]  fire = 9'h000;
	logic [16:0] lf = 17'h13130;
	logic        ack, ovf, per, cc1, syn, conv, cc2, rxok, txtk, txld, pirq, irq;
	logic [7:0]  rxb, txb, opt;
	logic [7:0]  rx_q[$], tx_q[$];
	int          n_fail = 0, total_checks = 0, cyc_cnt = 0;
	int          bl[5] = '{0, 1, 2, 3, 6};

	always #12.5 clk = ~clk;

	pif_irq_flags DUT (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.gate_active(gate), .conv_done(conv), .sync_serial_done(syn), .capcmp_one_evt(cc1),
		.capcmp_one_pwm(pwm1), .capcmp_two_evt(cc2), .capcmp_two_pwm(pwm2), .period_match(per),
		.wide_timer_ovf(ovf), .rx_byte_valid(rxok), .rx_byte(rxb), .tx_taken(txtk),
		.tx_byte(txb), .tx_load(txld), .periph_irq(pirq), .irq(irq), .option_settings(opt));

	pif_periph_model PER (.clk(clk), .srst(srst), .fire(fire), .rx_val(rxv), .slow(slow),
		.tx_load(txld), .wide_timer_ovf(ovf), .period_match(per), .capcmp_one_evt(cc1),
		.sync_serial_done(syn), .conv_done(conv), .capcmp_two_evt(cc2), .rx_byte_valid(rxok),
		.rx_byte(rxb), .tx_taken(txtk));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [16:0] lfsr(logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr

	task automatic results();
		if (n_fail == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	task automatic chk_rd(string nm, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk_rd

	task automatic chk_pin(string nm, logic e, logic g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask : chk_pin

	task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= s;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rd = dat_o;
		cyc <= 0; stb <= 0; we <= 0;
	endtask : wb

	task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
		wb(0, a, 32'h0);
		chk_rd(nm, e, rd);
	endtask : rdc

	task automatic ev(logic [8:0] b);
		@(posedge clk);
		fire <= b;
		@(posedge clk);
		fire <= 9'h000;
		repeat (3) @(posedge clk);
	endtask : ev

	task automatic pin_after(string nm, logic e, logic g_sel);
		repeat (2) @(posedge clk);
		#1;
		chk_pin(nm, e, g_sel ? irq : pirq);
	endtask : pin_after

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_fail++;
			results();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rdc("ctrl", pif_pkg::OFS_CTRL, 32'h00);
		rdc("req1", pif_pkg::OFS_REQ1, 32'h90);
		rdc("opt", pif_pkg::OFS_OPT, 32'hFF);
		rdc("unmapped", 8'h30, 32'h00);
		rdc("evst_rst", pif_pkg::OFS_EVST, 32'h000);
		wb(1, pif_pkg::OFS_EN2, 32'hFF);
		rdc("en2", pif_pkg::OFS_EN2, 32'h01);
		wb(1, pif_pkg::OFS_EN2, 32'h00);
		wb(1, pif_pkg::OFS_REQ1, 32'hFF);
		rdc("req1_wr", pif_pkg::OFS_REQ1, 32'hDF);
		wb(1, pif_pkg::OFS_REQ1, 32'h00);
		rdc("req1_clr", pif_pkg::OFS_REQ1, 32'h90);
		foreach (bl[i]) begin
			wb(1, pif_pkg::OFS_EVMSK, 32'h1 << bl[i]);
			ev(9'h001 << bl[i]);
			rdc("req1_ev", pif_pkg::OFS_REQ1, 32'h90 | (32'h1 << bl[i]));
			chk_pin("irq", 1'b1, irq);
			rdc("evst", pif_pkg::OFS_EVST, 32'h1 << bl[i]);
			pin_after("irq_clr", 1'b0, 1'b1);
			wb(1, pif_pkg::OFS_EN1, 32'h1 << bl[i]);
			for (int c = 0; c < 4; c++) begin
				wb(1, pif_pkg::OFS_CTRL, 32'(c) << 6);
				pin_after("pirq", logic'(c == 3), 1'b0);
			end
			wb(1, pif_pkg::OFS_REQ1, 32'h00);
			pin_after("pirq_clr", 1'b0, 1'b0);
			wb(1, pif_pkg::OFS_EN1, 32'h00);
			wb(1, pif_pkg::OFS_CTRL, 32'h00);
		end
		pwm1 <= 1'b1;
		pwm2 <= 1'b1;
		ev(9'h104);
		rdc("req1_pwm", pif_pkg::OFS_REQ1, 32'h90);
		rdc("req2_pwm", pif_pkg::OFS_REQ2, 32'h00);
		pwm1 <= 1'b0;
		pwm2 <= 1'b0;
		ev(9'h100);
		rdc("req2", pif_pkg::OFS_REQ2, 32'h01);
		wb(1, pif_pkg::OFS_CTRL, 32'hC0);
		wb(1, pif_pkg::OFS_EN2, 32'h01);
		pin_after("pirq_cc2", 1'b1, 1'b0);
		wb(1, pif_pkg::OFS_EN2, 32'h00);
		pin_after("pirq_cc2_off", 1'b0, 1'b0);
		wb(1, pif_pkg::OFS_CTRL, 32'h00);
		gate <= 1'b1;
		rdc("req1_gate", pif_pkg::OFS_REQ1, 32'h10);
		wb(0, pif_pkg::OFS_EVST, 32'h0);
		gate <= 1'b0;
		rdc("evst_gate", pif_pkg::OFS_EVST, 32'h80);
		lf = lfsr(lf);
		rxv <= lf[7:0];
		rx_q.push_back(lf[7:0]);
		ev(9'h020);
		rdc("req1_rx", pif_pkg::OFS_REQ1, 32'hB0);
		rdc("rxd", pif_pkg::OFS_RXD, {24'h0, rx_q.pop_front()});
		rdc("req1_rxrd", pif_pkg::OFS_REQ1, 32'h90);
		wb(0, pif_pkg::OFS_EVST, 32'h0);
		lf = lfsr(lf);
		slow <= 8'h14;
		tx_q.push_back(lf[7:0]);
		wb(1, pif_pkg::OFS_TXD, {24'h0, lf[7:0]});
		chk_pin("tx_load", 1'b1, txld);
		rdc("req1_tx", pif_pkg::OFS_REQ1, 32'h80);
		chk_rd("tx_byte", {24'h0, tx_q.pop_front()}, {24'h0, txb});
		repeat (30) @(posedge clk);
		rdc("req1_txe", pif_pkg::OFS_REQ1, 32'h90);
		rdc("evst_tx", pif_pkg::OFS_EVST, 32'h10);
		lf = lfsr(lf);
		wb(1, pif_pkg::OFS_OPT, {24'h0, lf[7:0]});
		rdc("opt_wr", pif_pkg::OFS_OPT, {24'h0, lf[7:0]});
		chk_rd("opt_pin", {24'h0, lf[7:0]}, {24'h0, opt});
		wb(1, pif_pkg::OFS_OPT, 32'h00, 4'hE);
		rdc("opt_sel", pif_pkg::OFS_OPT, {24'h0, lf[7:0]});
		wb(1, 8'h30, 32'hFF);
		rdc("unmapped_wr", 8'h30, 32'h00);
		results();
	end
endmodule : tb_top
